// file: ads_pkg.sv
// constants and types of the analog die mode supervisor, plus its input synchroniser
package ads_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    // timeout supervision after any reset
    localparam int unsigned NORMREQ_MS = 80;
    localparam int unsigned NORMREQ_CYC = NORMREQ_MS * CLK_PER_MS;
    // length of a self-driven reset pulse
    localparam int unsigned RST_HOLD_US = 20;
    localparam int unsigned RST_HOLD_CYC = RST_HOLD_US * CLK_PER_US;
    // watchdog period and the early part of it in which a service is wrong
    localparam int unsigned WD_TIMEOUT_MS = 50;
    localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_PER_MS;
    localparam int unsigned WD_WINDOW_CYC = WD_TIMEOUT_CYC / 2;
    // inrush auto pulsing of the high side switches
    localparam int unsigned PULSE_US = 100;
    localparam int unsigned PULSE_CYC = PULSE_US * CLK_PER_US;
    localparam logic [3:0] INRUSH_TICKS = 4'h8;
    // released-pin blanking so our own pulse is not read back as external
    localparam logic [3:0] GUARD_CYC = 4'hf;
    localparam logic [3:0] AMUX_SRC_CNT = 4'hb;
    localparam int unsigned HS_CNT = 3;
    // synchronised pin positions
    localparam int unsigned PIN_STRAP = 0;
    localparam int unsigned PIN_RST = 1;
    localparam int unsigned PIN_LIN = 2;
    localparam int unsigned PIN_WAKE = 3;
    localparam int unsigned PIN_PWM = 4;
    localparam int unsigned PIN_CNT = 5;
    // interrupt flag / enable positions
    localparam int unsigned FLG_WAKE = 0;
    localparam int unsigned FLG_LIN = 1;
    // reset cause bits
    localparam int unsigned CAUSE_POR = 0;
    localparam int unsigned CAUSE_EXT = 1;
    localparam int unsigned CAUSE_WDOG = 2;
    localparam int unsigned CAUSE_LIN = 3;
    localparam int unsigned CAUSE_WAKE = 4;
    localparam logic [4:0] CAUSE_RST_VAL = 5'h01;
    typedef enum logic [2:0] {M_RST, M_NRQ, M_NORM, M_STOP, M_SLEEP} ads_mode_t;
    typedef enum logic [1:0] {HALL_GPIO, HALL_3PIN, HALL_2PIN, HALL_BAD} ads_hall_t;
endpackage

////////////////////////////////////////////////////////////////////////////////
module ads_sync_edge #(
    parameter int unsigned W = 1
) (
    input wire logic mclk_i,            // clock
    input wire logic nrst_i,            // sync reset, low
    input wire logic [W-1:0] d_i,       // asynchronous pins
    input wire logic [W-1:0] rst_val_i, // idle level of each pin, loaded at reset
    output logic [W-1:0] lvl_o,         // synchronised level
    output logic [W-1:0] rise_o,        // one-cycle rising edge
    output logic [W-1:0] chg_o          // one-cycle any edge
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } ads_sync_t;
    ads_sync_t q, n;
    always_comb begin
        n.s1 = d_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
    end
    // every stage starts at the idle level, so release shows no false edge
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            q <= '{s1: rst_val_i, s2: rst_val_i, s3: rst_val_i};
        end else begin
            q <= n;
        end
    end
    assign lvl_o = q.s2;
    assign rise_o = q.s2 & ~q.s3;
    assign chg_o = q.s2 ^ q.s3;
endmodule

// file: ads_supervisor.sv
// mode, reset, wake and supervision logic of the analog companion die
// How it works
// - no power-stage-on bit by timeout expiry sends the die into Sleep
// - factory test strap high disables timeout supervision and the LIN receiver
// - watchdog resets on timeout expiry and on a too-early service
// - watchdog reset clears all control state except the reset cause register
// - three modes Normal, Stop, Sleep; stop and sleep bits select them
// - Normal keeps all stages available, each enabled by software, regulator on
// - Stop and Sleep are low-power modes left by a wake event
// - reset line is open-drain with pull-up, either side may pull it
// - enabled wake-input events in Normal or Stop and enabled LIN events in Stop pull the open-drain interrupt line low
// - four-bit select routes one of eleven analog sources to the converter
// - current source switchable on/off with four selectable magnitudes
// - hall input works as general input or three-pin/two-pin hall input
// - controller masters command and PWM inputs; die returns status
// - each high side switch auto-pulses for inrush or follows the PWM input
// - sleep bit enters Sleep: regulator off, reset line held low
// - in Sleep, wake input always wakes and LIN wakes while its receiver is enabled, like power-on, cause recorded
// - in Stop, enabled LIN or wake input wakes and raises an interrupt
// - every reset clears all interrupt enables
module ads_supervisor import ads_pkg::*; #(
    parameter int unsigned NORMREQ_CYCLES = ads_pkg::NORMREQ_CYC,
    parameter int unsigned WD_CYCLES = ads_pkg::WD_TIMEOUT_CYC,
    parameter int unsigned WD_WIN_CYCLES = ads_pkg::WD_WINDOW_CYC
) (
    input wire logic mclk_i,                   // 25 MHz clock
    input wire logic nrst_i,                   // power-on reset, sync, low
    input wire logic test_strap_i,             // factory_test_strap pin
    input wire logic rst_a_i,                  // reset line level
    output logic rst_a_o,                      // reset line data, always low
    output logic rst_a_oe_n_o,                 // low while pulling reset
    output logic irq_a_o,                      // interrupt line data, always low
    output logic irq_a_oe_n_o,                 // low while interrupt pending
    input wire logic lin_rx_i,                 // LIN receiver, low = dominant
    input wire logic wake_i,                   // wake_input pin
    input wire logic pwm_i,                    // PWM from controller
    input wire logic ctl_wr_i,                 // system control write pulse
    input wire logic power_stage_on_bit_wr_i,                // power_stage_on_bit data
    input wire logic stop_wr_i,                // stop bit data
    input wire logic sleep_wr_i,               // sleep bit data
    input wire logic wd_en_i,                  // watchdog enable
    input wire logic wd_kick_i,                // watchdog service pulse
    input wire logic cfg_wr_i,                 // configuration write pulse
    input wire logic [3:0] amux_sel_i,         // analog_mux_control source
    input wire logic cs_en_i,                  // current source on
    input wire logic [1:0] cs_sel_i,           // current source magnitude
    input wire logic [1:0] hall_mode_i,        // hall_input mode
    input wire logic [HS_CNT-1:0] hs_en_i,     // high_side_switch enables
    input wire logic [HS_CNT-1:0] hs_pwm_i,    // 1 = follow PWM, 0 = auto pulse
    input wire logic ie_wr_i,                  // interrupt enable write pulse
    input wire logic lin_ie_i,                 // lin_wake_irq_enable data
    input wire logic wake_ie_i,                // wake_input_irq_enable data
    input wire logic [1:0] flag_clr_i,         // write-one-to-clear flags
    input wire logic [4:0] cause_clr_i,        // write-one-to-clear causes
    output ads_pkg::ads_mode_t mode_o,         // current mode
    output logic vdd_en_o,                     // regulator on
    output logic power_stage_on_bit_o,                       // power_stage_on_bit
    output logic stages_en_o,                  // power stages available
    output logic lin_rx_en_o,                  // LIN receiver enabled
    output logic lin_rxd_o,                    // LIN data to controller
    output logic [3:0] amux_sel_o,             // selected analog source
    output logic cs_en_o,                      // current source on
    output logic [1:0] cs_sel_o,               // current source magnitude
    output ads_pkg::ads_hall_t hall_mode_o,    // hall input mode
    output logic [HS_CNT-1:0] hs_o,            // high side gate drive
    output logic [1:0] irq_en_o,               // interrupt enables
    output logic [1:0] flags_o,                // interrupt flags
    output logic [4:0] cause_o                 // reset_cause_register
);
    localparam int unsigned CW = $clog2(NORMREQ_CYCLES + RST_HOLD_CYC + 1);
    localparam int unsigned WW = $clog2(WD_CYCLES + 1);
    localparam int unsigned DW = $clog2(PULSE_CYC + 1);

    if (NORMREQ_CYCLES < 1 || WD_CYCLES < 2 || WD_WIN_CYCLES >= WD_CYCLES) begin : g_bad_param
        $error("ads_supervisor: timing parameters out of range");
    end

    typedef struct packed {
        ads_mode_t mode;
        logic [CW-1:0] cnt;
        logic [WW-1:0] wd_cnt;
        logic [3:0] guard;
        logic power_stage_on_bit;
        logic vdd_en;
        logic rst_drv;
        logic irq_drv;
        logic stg;
        logic lin_rx_en;
        logic lin_rxd;
        logic [3:0] amux;
        logic cs_en;
        logic [1:0] cs_sel;
        ads_hall_t hall;
        logic [HS_CNT-1:0] hs_en;
        logic [HS_CNT-1:0] hs_pwm;
        logic [HS_CNT-1:0] hs_out;
        logic [HS_CNT-1:0][3:0] inr;
        logic [DW-1:0] div;
        logic ph;
        logic [1:0] ie;
        logic [1:0] flags;
        logic [4:0] cause;
    } ads_state_t;

    localparam ads_state_t ST_RST = '{mode: M_RST, hall: HALL_GPIO, vdd_en: 1'b1, rst_drv: 1'b1,
        lin_rx_en: 1'b1, lin_rxd: 1'b1, guard: GUARD_CYC, cause: CAUSE_RST_VAL, default: '0};

    ////////////////////////////////////////////////////////////////////////////
    logic [PIN_CNT-1:0] pin_s, pin_rise, pin_chg;
    ads_sync_edge #(.W(PIN_CNT)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i({pwm_i, wake_i, lin_rx_i, rst_a_i, test_strap_i}),
        .rst_val_i(5'h04),                     // idle: LIN recessive, others low
        .lvl_o(pin_s),
        .rise_o(pin_rise),
        .chg_o(pin_chg)
    );

    ads_state_t q, n;
    logic strap_s, lin_wake, wake_chg, ext_rst, wd_bad, wd_to, rst_evt, tick;
    logic [4:0] cset;
    logic [1:0] fset;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        cset = 5'h00;
        fset = 2'h0;
        rst_evt = 1'b0;
        strap_s = pin_s[PIN_STRAP];
        // dominant to recessive edge, only with the receiver enabled
        lin_wake = pin_rise[PIN_LIN] & q.lin_rx_en;
        wake_chg = pin_chg[PIN_WAKE];
        // the pin reads low for a while after we let go; blank that echo
        ext_rst = !q.rst_drv && q.guard == 4'h0 && !pin_s[PIN_RST];
        wd_bad = q.mode == M_NORM && wd_en_i && wd_kick_i && q.wd_cnt < WW'(WD_WIN_CYCLES);
        wd_to = q.mode == M_NORM && wd_en_i && q.wd_cnt == WW'(WD_CYCLES - 1);
        tick = q.div == DW'(PULSE_CYC - 1);
        n.div = tick ? '0 : q.div + 1'b1;
        n.ph = q.ph ^ tick;
        if (q.mode == M_NORM && wd_en_i) begin
            n.wd_cnt = wd_kick_i ? '0 : q.wd_cnt + 1'b1;
        end else begin
            n.wd_cnt = '0;
        end
        if (ext_rst) begin
            rst_evt = 1'b1;
            cset[CAUSE_EXT] = 1'b1;
        end
        case (q.mode)
            M_RST: begin
                if (q.cnt == CW'(RST_HOLD_CYC - 1)) begin
                    n.mode = M_NRQ;
                    n.cnt = '0;
                end else begin
                    n.cnt = q.cnt + 1'b1;
                end
            end
            M_NRQ: begin
                if (ctl_wr_i && sleep_wr_i) begin
                    n.mode = M_SLEEP;
                end else if (ctl_wr_i && power_stage_on_bit_wr_i) begin
                    n.mode = M_NORM;
                    n.power_stage_on_bit = 1'b1;
                end else if (!strap_s) begin
                    if (q.cnt == CW'(NORMREQ_CYCLES - 1)) begin
                        n.mode = M_SLEEP;
                    end else begin
                        n.cnt = q.cnt + 1'b1;
                    end
                end
            end
            M_NORM: begin
                if (wd_bad || wd_to) begin
                    rst_evt = 1'b1;
                    cset[CAUSE_WDOG] = 1'b1;
                end else if (ctl_wr_i && sleep_wr_i) begin
                    n.mode = M_SLEEP;
                end else if (ctl_wr_i && stop_wr_i) begin
                    n.mode = M_STOP;
                end
                fset[FLG_WAKE] = wake_chg;
            end
            M_STOP: begin
                fset[FLG_LIN] = lin_wake && q.ie[FLG_LIN];
                fset[FLG_WAKE] = wake_chg && q.ie[FLG_WAKE];
                if (fset != 2'h0) begin
                    n.mode = M_NORM;
                end
            end
            M_SLEEP: begin
                if (lin_wake || wake_chg) begin
                    rst_evt = 1'b1;
                    cset[CAUSE_LIN] = lin_wake;
                    cset[CAUSE_WAKE] = wake_chg;
                end
            end
            default: n.mode = M_RST;
        endcase
        if (cfg_wr_i && q.mode != M_RST && q.mode != M_SLEEP) begin
            if (amux_sel_i < AMUX_SRC_CNT) begin
                n.amux = amux_sel_i;
            end
            n.cs_en = cs_en_i;
            n.cs_sel = cs_sel_i;
            if (ads_hall_t'(hall_mode_i) != HALL_BAD) begin
                n.hall = ads_hall_t'(hall_mode_i);
            end
            n.hs_en = hs_en_i;
            n.hs_pwm = hs_pwm_i;
        end
        if (ie_wr_i) begin
            n.ie = {lin_ie_i, wake_ie_i};
        end
        // a new event outweighs a clear in the same cycle
        n.flags = (q.flags & ~flag_clr_i) | fset;
        n.cause = (q.cause & ~cause_clr_i) | cset;
        if (rst_evt) begin
            n = ST_RST;
            n.cause = (q.cause & ~cause_clr_i) | cset;
        end
        n.rst_drv = n.mode == M_RST || n.mode == M_SLEEP;
        n.vdd_en = n.mode != M_SLEEP;
        if (n.rst_drv) begin
            n.guard = GUARD_CYC;
        end else if (q.guard != 4'h0) begin
            n.guard = q.guard - 1'b1;
        end
        n.irq_drv = |(n.flags & n.ie);
        n.lin_rx_en = !strap_s;
        n.lin_rxd = n.lin_rx_en ? pin_s[PIN_LIN] : 1'b1;
        n.stg = n.mode == M_NORM && n.power_stage_on_bit;
        for (int i = 0; i < HS_CNT; i++) begin
            if (!n.stg || !n.hs_en[i]) begin
                n.hs_out[i] = 1'b0;
                n.inr[i] = 4'h0;
            end else if (n.hs_pwm[i]) begin
                n.hs_out[i] = pin_s[PIN_PWM];
            end else if (q.inr[i] < INRUSH_TICKS) begin
                n.hs_out[i] = q.ph;
                n.inr[i] = q.inr[i] + {3'h0, tick};
            end else begin
                n.hs_out[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rst_a_o = 1'b0;
    assign irq_a_o = 1'b0;
    assign rst_a_oe_n_o = !q.rst_drv;
    assign irq_a_oe_n_o = !q.irq_drv;
    assign mode_o = q.mode;
    assign vdd_en_o = q.vdd_en;
    assign power_stage_on_bit_o = q.power_stage_on_bit;
    assign stages_en_o = q.stg;
    assign lin_rx_en_o = q.lin_rx_en;
    assign lin_rxd_o = q.lin_rxd;
    assign amux_sel_o = q.amux;
    assign cs_en_o = q.cs_en;
    assign cs_sel_o = q.cs_sel;
    assign hall_mode_o = q.hall;
    assign hs_o = q.hs_out;
    assign irq_en_o = q.ie;
    assign flags_o = q.flags;
    assign cause_o = q.cause;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_nrq_sleep: assert property (q.mode == M_NRQ && !strap_s && !ext_rst && !ctl_wr_i
        && q.cnt == CW'(NORMREQ_CYCLES - 1) |=> mode_o == M_SLEEP && !vdd_en_o)
        else $error("timeout did not enter sleep");
    a_strap_hold: assert property (q.mode == M_NRQ && strap_s && !ext_rst && !ctl_wr_i
        |=> mode_o == M_NRQ && $stable(q.cnt))
        else $error("timeout ran under test strap");
    a_strap_lin: assert property (strap_s |=> !lin_rx_en_o && lin_rxd_o)
        else $error("lin receiver on under test strap");
    a_wd_early: assert property (q.mode == M_NORM && wd_en_i && wd_kick_i
        && q.wd_cnt < WW'(WD_WIN_CYCLES) |=> mode_o == M_RST && !rst_a_oe_n_o)
        else $error("early service did not reset");
    a_wd_keep: assert property ((wd_bad || wd_to) && !ext_rst && q.cause[CAUSE_POR] && cause_clr_i == 5'h00
        |=> cause_o[CAUSE_WDOG] && cause_o[CAUSE_POR] && irq_en_o == 2'h0 && !power_stage_on_bit_o)
        else $error("watchdog reset lost cause or kept state");
    a_sleep_pins: assert property (mode_o == M_SLEEP |-> !vdd_en_o && !rst_a_oe_n_o && hs_o == '0)
        else $error("sleep not holding reset and regulator");
    a_sleep_wake: assert property (q.mode == M_SLEEP && wake_chg |=> mode_o == M_RST
        && cause_o[CAUSE_WAKE] && vdd_en_o ##[1:600] mode_o == M_NRQ)
        else $error("sleep wake not like power-on");
    a_stop_mask: assert property (q.mode == M_STOP && !ext_rst && !q.ie[FLG_WAKE]
        && wake_chg && !lin_wake |=> mode_o == M_STOP)
        else $error("masked wake left stop");
    a_stop_irq: assert property (q.mode == M_STOP && !ext_rst && lin_wake && q.ie[FLG_LIN]
        && !ie_wr_i |=> !irq_a_oe_n_o && flags_o[FLG_LIN] && mode_o == M_NORM)
        else $error("stop wake gave no interrupt");
    a_power_stage_on_bit_go: assert property (q.mode == M_NRQ && !ext_rst && ctl_wr_i && power_stage_on_bit_wr_i
        && !sleep_wr_i |=> mode_o == M_NORM && power_stage_on_bit_o ##1 (mode_o != M_SLEEP || $past(ctl_wr_i)))
        else $error("power stage bit did not stop timeout");
    a_stage_gate: assert property (mode_o != M_NORM |-> hs_o == '0 && !stages_en_o)
        else $error("stages active outside normal");

    c_timeout_sleep: cover property (q.mode == M_NRQ ##1 mode_o == M_SLEEP);
    c_stop_wake: cover property (mode_o == M_STOP ##1 mode_o == M_NORM);
    c_wd_reset: cover property (q.mode == M_NORM && (wd_bad || wd_to));
    c_sleep_wake: cover property (mode_o == M_SLEEP ##1 mode_o == M_RST);
endmodule

// file: ads_mcu_model.sv
// controller-side model: resolves the open-drain reset and interrupt wires
module ads_mcu_model (
    input wire logic rst_oe_n_i, // die pulls reset line
    input wire logic irq_oe_n_i, // die pulls interrupt line
    input wire logic rst_pull_i, // controller pulls reset line
    output logic rst_line_o,     // resolved reset wire
    output logic irq_line_o      // resolved interrupt wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up only wins while nobody pulls low
    assign rst_line_o = !(!rst_oe_n_i || rst_pull_i);
    assign irq_line_o = irq_oe_n_i;
endmodule

// file: analog_die_mode_supervisor_tb.sv
// self-checking bench of the analog die mode supervisor
module analog_die_mode_supervisor_tb import ads_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic nrst_i, test_strap_i, rst_line, irq_line, rst_a_o, rst_oe_n, irq_a_o, irq_oe_n;
    logic lin_rx_i, wake_i, pwm_i, ctl_wr_i, power_stage_on_bit_wr_i, stop_wr_i, sleep_wr_i, wd_en_i, wd_kick_i;
    logic cfg_wr_i, cs_en_i, ie_wr_i, lin_ie_i, wake_ie_i, vdd_en_o, power_stage_on_bit_o, stages_en_o;
    logic lin_rx_en_o, lin_rxd_o, cs_en_o, rst_pull;
    logic [3:0] amux_sel_i, amux_sel_o, e_amux;
    logic [1:0] cs_sel_i, hall_mode_i, flag_clr_i, irq_en_o, flags_o, cs_sel_o, e_hall;
    logic [2:0] hs_en_i, hs_pwm_i, hs_o;
    logic [4:0] cause_clr_i, cause_o;
    logic [31:0] seed;
    ads_mode_t mode_o;
    ads_hall_t hall_mode_o;
    int num_errors = 0;
    int n_compared = 0;
    ads_supervisor #(.NORMREQ_CYCLES(200), .WD_CYCLES(100), .WD_WIN_CYCLES(50)) ads_supervisor_i (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .test_strap_i(test_strap_i), .rst_a_i(rst_line),
        .rst_a_o(rst_a_o), .rst_a_oe_n_o(rst_oe_n), .irq_a_o(irq_a_o), .irq_a_oe_n_o(irq_oe_n),
        .lin_rx_i(lin_rx_i), .wake_i(wake_i), .pwm_i(pwm_i), .ctl_wr_i(ctl_wr_i), .power_stage_on_bit_wr_i(power_stage_on_bit_wr_i),
        .stop_wr_i(stop_wr_i), .sleep_wr_i(sleep_wr_i), .wd_en_i(wd_en_i), .wd_kick_i(wd_kick_i),
        .cfg_wr_i(cfg_wr_i), .amux_sel_i(amux_sel_i), .cs_en_i(cs_en_i), .cs_sel_i(cs_sel_i),
        .hall_mode_i(hall_mode_i), .hs_en_i(hs_en_i), .hs_pwm_i(hs_pwm_i), .ie_wr_i(ie_wr_i),
        .lin_ie_i(lin_ie_i), .wake_ie_i(wake_ie_i), .flag_clr_i(flag_clr_i), .cause_clr_i(cause_clr_i),
        .mode_o(mode_o), .vdd_en_o(vdd_en_o), .power_stage_on_bit_o(power_stage_on_bit_o), .stages_en_o(stages_en_o),
        .lin_rx_en_o(lin_rx_en_o), .lin_rxd_o(lin_rxd_o), .amux_sel_o(amux_sel_o), .cs_en_o(cs_en_o),
        .cs_sel_o(cs_sel_o), .hall_mode_o(hall_mode_o), .hs_o(hs_o), .irq_en_o(irq_en_o),
        .flags_o(flags_o), .cause_o(cause_o));
    ads_mcu_model ads_mcu_model_i (.rst_oe_n_i(rst_oe_n), .irq_oe_n_i(irq_oe_n), .rst_pull_i(rst_pull),
        .rst_line_o(rst_line), .irq_line_o(irq_line));
    always #20 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // refused values leave the old setting in place
    function automatic logic [3:0] pick(input logic ok, input logic [3:0] v, input logic [3:0] old);
        return ok ? v : old;
    endfunction
    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait, then the mode itself is compared
    task automatic wait_mode(input ads_mode_t m, input int lim);
        int k;
        k = 0;
        while (mode_o !== m && k < lim) begin
            @(negedge mclk_i);
            k++;
        end
        chk("mode", mode_o, m);
    endtask
    task automatic ctl(input logic p, input logic s, input logic sl);
        @(posedge mclk_i);
        ctl_wr_i <= 1'b1;
        power_stage_on_bit_wr_i <= p;
        stop_wr_i <= s;
        sleep_wr_i <= sl;
        @(posedge mclk_i);
        ctl_wr_i <= 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        num_errors++;
        test_done();
    end
    initial begin
        {nrst_i, test_strap_i, wake_i, pwm_i, ctl_wr_i, power_stage_on_bit_wr_i, stop_wr_i, sleep_wr_i} = 8'h00;
        {wd_en_i, wd_kick_i, cfg_wr_i, cs_en_i, ie_wr_i, lin_ie_i, wake_ie_i} = 7'h00;
        {amux_sel_i, cs_sel_i, hall_mode_i, flag_clr_i, cause_clr_i} = 15'h0000;
        lin_rx_i = 1'b1;
        rst_pull = 1'b0;
        hs_en_i = 3'h7;
        hs_pwm_i = 3'h7;
        seed = 32'h1971;
        e_amux = 4'h0;
        e_hall = 2'h0;
        cycles(10);
        chk("cause", cause_o, 5'h01);
        chk("irq_en", irq_en_o, 2'h0);
        chk("rst_oe_n", rst_oe_n, 1'b0);
        chk("od_data", {rst_a_o, irq_a_o}, 2'h0);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        wait_mode(M_NRQ, 600);
        cycles(190);
        chk("mode", mode_o, M_NRQ);
        wait_mode(M_SLEEP, 20);
        chk("vdd_en", vdd_en_o, 1'b0);
        chk("rst_line", rst_line, 1'b0);
        @(posedge mclk_i);
        wake_i <= ~wake_i;
        wait_mode(M_RST, 8);
        chk("cause", cause_o, 5'h11);
        wait_mode(M_NRQ, 600);
        ctl(1'b1, 1'b0, 1'b0);
        chk("mode", mode_o, M_NORM);
        chk("stages", {stages_en_o, power_stage_on_bit_o, vdd_en_o}, 3'h7);
        cycles(250);
        chk("mode", mode_o, M_NORM);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            @(posedge mclk_i);
            cfg_wr_i <= 1'b1;
            amux_sel_i <= (i == 0) ? 4'ha : (i == 1) ? 4'hb : seed[3:0];
            {cs_sel_i, cs_en_i} <= seed[6:4];
            hall_mode_i <= seed[8:7];
            @(posedge mclk_i);
            cfg_wr_i <= 1'b0;
            @(negedge mclk_i);
            e_amux = pick(amux_sel_i < AMUX_SRC_CNT, amux_sel_i, e_amux);
            e_hall = 2'(pick(hall_mode_i != 2'h3, {2'h0, hall_mode_i}, {2'h0, e_hall}));
            chk("amux_sel", amux_sel_o, e_amux);
            chk("cs", {cs_sel_o, cs_en_o}, seed[6:4]);
            chk("hall", hall_mode_o, e_hall);
        end
        @(posedge mclk_i);
        pwm_i <= 1'b1;
        cycles(8);
        chk("hs", hs_o, 3'h7);
        @(posedge mclk_i);
        pwm_i <= 1'b0;
        cycles(8);
        chk("hs", hs_o, 3'h0);
        @(posedge mclk_i);
        {ie_wr_i, lin_ie_i, wake_ie_i} <= 3'h7;
        @(posedge mclk_i);
        ie_wr_i <= 1'b0;
        cycles(1);
        chk("irq_en", irq_en_o, 2'h3);
        ctl(1'b0, 1'b1, 1'b0);
        chk("mode", mode_o, M_STOP);
        @(posedge mclk_i);
        wake_i <= ~wake_i;
        wait_mode(M_NORM, 10);
        cycles(1);
        chk("wake_flag", flags_o[0], 1'b1);
        chk("irq_line", irq_line, 1'b0);
        @(posedge mclk_i);
        flag_clr_i <= 2'h3;
        @(posedge mclk_i);
        flag_clr_i <= 2'h0;
        cycles(2);
        chk("irq_line", {irq_line, flags_o}, 3'h4);
        // lin wake only: a wake pin edge in stop must now be ignored
        @(posedge mclk_i);
        {ie_wr_i, lin_ie_i, wake_ie_i} <= 3'h6;
        @(posedge mclk_i);
        ie_wr_i <= 1'b0;
        ctl(1'b0, 1'b1, 1'b0);
        @(posedge mclk_i);
        wake_i <= ~wake_i;
        cycles(8);
        chk("mode", mode_o, M_STOP);
        @(posedge mclk_i);
        lin_rx_i <= 1'b0;
        cycles(4);
        chk("lin_rxd", lin_rxd_o, 1'b0);
        @(posedge mclk_i);
        lin_rx_i <= 1'b1;
        wait_mode(M_NORM, 10);
        cycles(1);
        chk("irq_line", {irq_line, flags_o}, 3'h2);
        @(posedge mclk_i);
        wd_en_i <= 1'b1;
        wd_kick_i <= 1'b1;
        @(posedge mclk_i);
        wd_kick_i <= 1'b0;
        wait_mode(M_RST, 8);
        chk("cause", cause_o, 5'h15);
        chk("irq_en", irq_en_o, 2'h0);
        chk("amux_sel", amux_sel_o, 4'h0);
        @(posedge mclk_i);
        wd_en_i <= 1'b0;
        test_strap_i <= 1'b1;
        wait_mode(M_NRQ, 600);
        cycles(260);
        chk("mode", mode_o, M_NRQ);
        chk("lin_rx_en", lin_rx_en_o, 1'b0);
        @(posedge mclk_i);
        lin_rx_i <= 1'b0;
        cycles(4);
        chk("lin_rxd", lin_rxd_o, 1'b1);
        // controller side pulls the shared reset wire
        @(posedge mclk_i);
        lin_rx_i <= 1'b1;
        rst_pull <= 1'b1;
        wait_mode(M_RST, 8);
        chk("cause", cause_o, 5'h17);
        @(posedge mclk_i);
        rst_pull <= 1'b0;
        wait_mode(M_NRQ, 600);
        test_done();
    end
endmodule
